// ===== rtl/nps_pkg.sv
/*
 Shared constants, types and field layouts of the flash/EEPROM page
 programming sequencer.
 Assumes one 100 MHz system clock and a 128K-byte flash organised as
 32-word pages, with the boot loader section at the top of the flash.
*/
package nps_pkg;

   ////////////////////////////////////////////////////////////////////////
   // pointer layout: page extension : high byte : low byte
   localparam int NPS_PTR_W = 24;
   localparam int NPS_WORD_FIELD_TOP_BIT = 5;
   localparam int NPS_PAGE_FIELD_TOP_BIT = 16;
   localparam int NPS_WADDR_W = NPS_PAGE_FIELD_TOP_BIT;
   localparam int NPS_WORD_IN_PAGE_INDEX_W = NPS_WORD_FIELD_TOP_BIT;
   localparam int NPS_FLASH_PAGE_INDEX_W = NPS_PAGE_FIELD_TOP_BIT - NPS_WORD_FIELD_TOP_BIT;
   localparam int NPS_FBUF_WORDS = 32;

   // eeprom page buffer: byte index in low pointer bits, page above
   localparam int NPS_EE_BYTE_W = 5;
   localparam int NPS_EE_BYTES = 32;
   localparam int NPS_EE_PAGE_W = 7;
   localparam int NPS_EE_PAGE_LSB = 5;

   // flash sections, in word addresses
   localparam logic [15:0] NPS_BOOT_START_W = 16'hF000;
   localparam logic [15:0] NPS_APP_LAST_W = 16'hEFFF;
   localparam logic [15:0] NPS_FLASH_FIRST_W = 16'h0000;
   localparam logic [15:0] NPS_FLASH_LAST_W = 16'hFFFF;

   ////////////////////////////////////////////////////////////////////////
   // checksum
   localparam int NPS_CRC_W = 24;
   localparam logic [23:0] NPS_CRC_POLY = 24'h00000B;
   localparam logic [23:0] NPS_CRC_INIT = 24'h000000;

   ////////////////////////////////////////////////////////////////////////
   // timing
   localparam int NPS_CLK_MHZ = 100;
   localparam int NPS_PAGE_OP_MS = 4;
   localparam int NPS_PAGE_OP_CYC = NPS_PAGE_OP_MS * 1000 * NPS_CLK_MHZ;
   localparam int NPS_CNT_W = 20;

   ////////////////////////////////////////////////////////////////////////
   // reset values
   localparam logic [15:0] NPS_FBUF_ERASED = 16'hFFFF;
   localparam logic [7:0] NPS_EBUF_RST = 8'hFF;
   localparam logic [7:0] NPS_LOCK_RST = 8'hFF;
   localparam logic [15:0] NPS_WADDR_RST = 16'h0000;

   typedef enum logic [3:0] {
      NPS_OP_NOP = 4'h0,
      NPS_OP_FL_BUF_LOAD = 4'h1,
      NPS_OP_FL_BUF_ERASE = 4'h2,
      NPS_OP_FL_ERASE = 4'h3,
      NPS_OP_FL_WRITE = 4'h4,
      NPS_OP_FL_ERASE_WRITE = 4'h5,
      NPS_OP_EE_BUF_LOAD = 4'h6,
      NPS_OP_EE_ERASE = 4'h7,
      NPS_OP_EE_WRITE = 4'h8,
      NPS_OP_EE_ERASE_WRITE = 4'h9,
      NPS_OP_SIG_ERASE = 4'hA,
      NPS_OP_SIG_WRITE = 4'hB,
      NPS_OP_CRC_APP = 4'hC,
      NPS_OP_CRC_BOOT = 4'hD,
      NPS_OP_CRC_RANGE = 4'hE,
      NPS_OP_LOCK_WRITE = 4'hF
   } nps_op_t;

   typedef enum logic [1:0] {
      NPS_TGT_FLASH = 2'h0,
      NPS_TGT_EE = 2'h1,
      NPS_TGT_SIG = 2'h2,
      NPS_TGT_NONE = 2'h3
   } nps_tgt_t;

   typedef enum logic [1:0] {
      NPS_ST_IDLE = 2'h0,
      NPS_ST_PROG = 2'h1,
      NPS_ST_CRC = 2'h2
   } nps_state_t;

   typedef struct packed {
      nps_op_t op;
      logic [23:0] ptr;
      logic [23:0] range_end;
      logic [15:0] data;
      logic from_boot;
      logic from_ext;
   } nps_cmd_t;

   typedef struct packed {
      logic erase;
      logic write;
      nps_tgt_t target;
      logic [10:0] page;
   } nps_prog_t;

   localparam nps_prog_t NPS_PROG_RST = '{erase: 1'b0, write: 1'b0, target: NPS_TGT_NONE, page: 11'h000};

endpackage

// ===== rtl/nps_crc_step.sv
/*
 One clock's worth of checksum update: folds a whole data word into the
 24-bit remainder, most significant data bit first.
 Assumes the caller registers the result; purely combinational.
*/
`timescale 1ns/1ps

module nps_crc_step
   import nps_pkg::*;
#(
   parameter int DW = 16
) (
   input wire logic [NPS_CRC_W-1:0] crc_in,
   input wire logic [DW-1:0] data_in,
   output logic [NPS_CRC_W-1:0] crc_out
);

   always_comb begin
      logic [NPS_CRC_W-1:0] c;
      logic fb;
      c = crc_in;
      fb = 1'b0;
      for (int i = DW - 1; i >= 0; i--) begin
         fb = c[NPS_CRC_W-1] ^ data_in[i];
         c = {c[NPS_CRC_W-2:0], 1'b0};
         if (fb) begin
            c = c ^ NPS_CRC_POLY;
         end
      end
      crc_out = c;
   end

endmodule

// ===== rtl/nps_sequencer.sv
/*
 Page programming sequencer of the non-volatile memory controller:
 command acceptance, page buffers, timed page operations, CPU halt and
 stall, brown-out abort, flash checksum and byte reads of flash.
 Assumes the command source, CPU fetch port and flash read array run on
 clk; rd_word answers rd_addr_q combinationally in the same cycle. The
 brown-out reset arrives from a pin and is synchronised here.
*/
`timescale 1ns/1ps

// Summary of operation
// - flash orders: fill then split erase/write, fill then atomic, or erase-fill-write.
// - eeprom orders: fill then split erase/write, or fill then combined erase-write.
// - brown-out detector is switched on automatically while a flash write runs.
// - a brown-out reset aborts any running programming at once.
// - checksum over application section, boot section or a chosen address range.
// - CPU is halted from checksum start until the result is stored.
// - checksum consumes exactly one clock per flash word in the range.
// - checksum polynomial is fixed with terms of degree 24, 3, 1 and 0.
// - boot code may program flash, signature row, eeprom and tighten lock bits.
// - application code may only read flash but may read and write eeprom.
// - boot code may program any flash page, its own section included.
// - application page operations leave the CPU running from the boot section.
// - boot section page operations halt the CPU and block all reads.
// - signature row erase or write behaves like boot section programming.
// - touching the application section during programming stalls the CPU, reads fail.
// - pointer is built from low byte, high byte and a page extension byte.
// - pointer bits select word within page and page above that.
// - pointer bit 0 picks low or high byte for flash byte reads.
// - target address is latched at start; pointer may change afterwards.
// - busy while running; commands arriving then are ignored.
// - eeprom erase and write touch only tagged buffer locations.
module nps_sequencer
   import nps_pkg::*;
#(
   parameter int PAGE_OP_CYC = NPS_PAGE_OP_CYC
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic cmd_valid,
   input wire nps_cmd_t cmd,
   input wire logic rd_req,
   input wire logic [NPS_PTR_W-1:0] rd_ptr,
   input wire logic [15:0] rd_word,
   input wire logic cpu_fetch_valid,
   input wire logic [NPS_PTR_W-1:0] cpu_fetch_ptr,
   input wire logic brownout_reset_in,
   output logic busy_q,
   output logic cmd_refused_q,
   output logic cmd_done_q,
   output logic aborted_q,
   output logic cpu_halt_q,
   output logic brownout_detector_en_q,
   output logic prog_start_q,
   output nps_prog_t prog_req_q,
   output logic [NPS_FBUF_WORDS-1:0][15:0] fl_buf_q,
   output logic [NPS_EE_BYTES-1:0][7:0] ee_buf_q,
   output logic [NPS_EE_BYTES-1:0] ee_mask_q,
   output logic [7:0] lock_bits_q,
   output logic [NPS_CRC_W-1:0] crc_result_q,
   output logic [NPS_WADDR_W-1:0] rd_addr_q,
   output logic [7:0] rd_byte_q,
   output logic rd_valid_q,
   output logic rd_refused_q
);

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   nps_state_t state_q;
   nps_state_t state_d;
   logic [NPS_CNT_W-1:0] cnt_q;
   logic halt_all_q;
   logic halt_all_d;
   logic bo_meta_q;
   logic bo_sync_q;
   logic [NPS_WADDR_W-1:0] crc_end_q;
   logic [NPS_CRC_W-1:0] crc_acc_q;
   logic [NPS_CRC_W-1:0] crc_next;
   logic rd_sel_q;
   logic rd_pend_q;

   ////////////////////////////////////////////////////////////////////////
   // command decode

   nps_op_t op;
   logic [NPS_WADDR_W-1:0] cmd_waddr;
   logic [NPS_WADDR_W-1:0] cmd_end_waddr;
   logic is_fl_prog;
   logic is_ee_prog;
   logic is_sig;
   logic is_crc;
   logic needs_priv;
   logic bad_range;
   logic go;
   logic prog_go;
   logic crc_go;
   logic stalling_section;
   logic prog_last;
   logic crc_last;
   nps_prog_t prog_d;
   logic [NPS_WADDR_W-1:0] crc_start_w;
   logic [NPS_WADDR_W-1:0] crc_end_w;

   assign op = cmd.op;
   assign cmd_waddr = cmd.ptr[NPS_PAGE_FIELD_TOP_BIT:1];
   assign cmd_end_waddr = cmd.range_end[NPS_PAGE_FIELD_TOP_BIT:1];
   assign is_fl_prog = (op == NPS_OP_FL_ERASE) || (op == NPS_OP_FL_WRITE) || (op == NPS_OP_FL_ERASE_WRITE);
   assign is_ee_prog = (op == NPS_OP_EE_ERASE) || (op == NPS_OP_EE_WRITE) || (op == NPS_OP_EE_ERASE_WRITE);
   assign is_sig = (op == NPS_OP_SIG_ERASE) || (op == NPS_OP_SIG_WRITE);
   assign is_crc = (op == NPS_OP_CRC_APP) || (op == NPS_OP_CRC_BOOT) || (op == NPS_OP_CRC_RANGE);
   // application code may touch eeprom and buffers but never flash content
   assign needs_priv = is_fl_prog || is_sig || (op == NPS_OP_LOCK_WRITE);
   assign bad_range = (op == NPS_OP_CRC_RANGE) && (cmd_end_waddr < cmd_waddr);
   assign go = cmd_valid && !busy_q && !bo_sync_q && (op != NPS_OP_NOP) && !bad_range &&
               !(needs_priv && !cmd.from_boot && !cmd.from_ext);
   assign prog_go = go && (is_fl_prog || is_ee_prog || is_sig);
   assign crc_go = go && is_crc;
   // no page restriction: boot code may rewrite its own section
   assign stalling_section = is_sig || (is_fl_prog && (cmd_waddr >= NPS_BOOT_START_W));
   assign prog_last = (state_q == NPS_ST_PROG) && (cnt_q == NPS_CNT_W'(1));
   assign crc_last = (state_q == NPS_ST_CRC) && (rd_addr_q == crc_end_q);

   always_comb begin
      prog_d = NPS_PROG_RST;
      prog_d.erase = (op == NPS_OP_FL_ERASE) || (op == NPS_OP_FL_ERASE_WRITE) || (op == NPS_OP_EE_ERASE) ||
                     (op == NPS_OP_EE_ERASE_WRITE) || (op == NPS_OP_SIG_ERASE);
      prog_d.write = (op == NPS_OP_FL_WRITE) || (op == NPS_OP_FL_ERASE_WRITE) || (op == NPS_OP_EE_WRITE) ||
                     (op == NPS_OP_EE_ERASE_WRITE) || (op == NPS_OP_SIG_WRITE);
      if (is_fl_prog) begin
         prog_d.target = NPS_TGT_FLASH;
         prog_d.page = cmd.ptr[NPS_PAGE_FIELD_TOP_BIT:NPS_WORD_FIELD_TOP_BIT+1];
      end else if (is_ee_prog) begin
         prog_d.target = NPS_TGT_EE;
         prog_d.page = {4'h0, cmd.ptr[NPS_EE_PAGE_LSB+NPS_EE_PAGE_W-1:NPS_EE_PAGE_LSB]};
      end else if (is_sig) begin
         prog_d.target = NPS_TGT_SIG;
      end
   end

   always_comb begin
      crc_start_w = cmd_waddr;
      crc_end_w = cmd_end_waddr;
      case (op)
         NPS_OP_CRC_APP: begin
            crc_start_w = NPS_FLASH_FIRST_W;
            crc_end_w = NPS_APP_LAST_W;
         end
         NPS_OP_CRC_BOOT: begin
            crc_start_w = NPS_BOOT_START_W;
            crc_end_w = NPS_FLASH_LAST_W;
         end
         default: begin
            crc_start_w = cmd_waddr;
            crc_end_w = cmd_end_waddr;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // sequencer state

   always_comb begin
      state_d = state_q;
      halt_all_d = halt_all_q;
      case (state_q)
         NPS_ST_IDLE: begin
            if (prog_go) begin
               state_d = NPS_ST_PROG;
               halt_all_d = stalling_section;
            end else if (crc_go) begin
               state_d = NPS_ST_CRC;
               halt_all_d = 1'b1;
            end
         end
         NPS_ST_PROG: begin
            if (prog_last) begin
               state_d = NPS_ST_IDLE;
            end
         end
         NPS_ST_CRC: begin
            if (crc_last) begin
               state_d = NPS_ST_IDLE;
            end
         end
         default: begin
            state_d = NPS_ST_IDLE;
         end
      endcase
      if (bo_sync_q) begin
         state_d = NPS_ST_IDLE;
      end
      if (state_d == NPS_ST_IDLE) begin
         halt_all_d = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= NPS_ST_IDLE;
         halt_all_q <= 1'b0;
         busy_q <= 1'b0;
      end else begin
         state_q <= state_d;
         halt_all_q <= halt_all_d;
         busy_q <= (state_d != NPS_ST_IDLE);
      end
   end

   // page operations are timed here; erase-and-write takes two periods
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= '0;
      end else if (state_q == NPS_ST_IDLE && prog_go) begin
         cnt_q <= (prog_d.erase && prog_d.write) ? NPS_CNT_W'(2 * PAGE_OP_CYC) : NPS_CNT_W'(PAGE_OP_CYC);
      end else if (state_q == NPS_ST_PROG) begin
         cnt_q <= cnt_q - NPS_CNT_W'(1);
      end
   end

   // target latched once; later pointer changes do not reach the array
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prog_req_q <= NPS_PROG_RST;
         prog_start_q <= 1'b0;
      end else begin
         prog_start_q <= prog_go && (state_d == NPS_ST_PROG);
         if (prog_go && (state_d == NPS_ST_PROG)) begin
            prog_req_q <= prog_d;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cmd_refused_q <= 1'b0;
         cmd_done_q <= 1'b0;
         aborted_q <= 1'b0;
      end else begin
         cmd_refused_q <= cmd_valid && (op != NPS_OP_NOP) && !go;
         cmd_done_q <= ((prog_last || crc_last) && !bo_sync_q) ||
                       (go && !prog_go && !crc_go);
         aborted_q <= bo_sync_q && (state_q != NPS_ST_IDLE);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // brown-out: synchroniser and detector enable

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bo_meta_q <= 1'b0;
         bo_sync_q <= 1'b0;
      end else begin
         bo_meta_q <= brownout_reset_in;
         bo_sync_q <= bo_meta_q;
      end
   end

   // detector follows every flash or signature page operation, erase included
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         brownout_detector_en_q <= 1'b0;
      end else if (state_q == NPS_ST_IDLE) begin
         brownout_detector_en_q <= prog_go && (state_d == NPS_ST_PROG) && !is_ee_prog;
      end else if (state_d == NPS_ST_IDLE) begin
         brownout_detector_en_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // CPU halt and stall

   logic fetch_app;
   assign fetch_app = cpu_fetch_valid && (cpu_fetch_ptr[NPS_PAGE_FIELD_TOP_BIT:1] < NPS_BOOT_START_W);

   // registered, so a stalling fetch is held one cycle after it appears
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cpu_halt_q <= 1'b0;
      end else begin
         cpu_halt_q <= (state_d == NPS_ST_CRC) ||
                       ((state_d == NPS_ST_PROG) && halt_all_d) ||
                       ((state_d == NPS_ST_PROG) && fetch_app);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // page buffers and lock bits

   logic fl_clear;
   logic ee_clear;
   assign fl_clear = (go && (op == NPS_OP_FL_BUF_ERASE)) || (go && (op == NPS_OP_LOCK_WRITE)) ||
                     (prog_last && prog_req_q.write && (prog_req_q.target != NPS_TGT_EE));
   assign ee_clear = (go && (op == NPS_OP_LOCK_WRITE)) ||
                     (prog_last && prog_req_q.write && (prog_req_q.target == NPS_TGT_EE));

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         fl_buf_q <= {NPS_FBUF_WORDS{NPS_FBUF_ERASED}};
      end else if (fl_clear) begin
         fl_buf_q <= {NPS_FBUF_WORDS{NPS_FBUF_ERASED}};
      end else if (go && (op == NPS_OP_FL_BUF_LOAD)) begin
         fl_buf_q[cmd.ptr[NPS_WORD_FIELD_TOP_BIT:1]] <= cmd.data;
      end
   end

   // the mask goes with the page so the array skips untagged bytes
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ee_buf_q <= {NPS_EE_BYTES{NPS_EBUF_RST}};
         ee_mask_q <= '0;
      end else if (ee_clear) begin
         ee_buf_q <= {NPS_EE_BYTES{NPS_EBUF_RST}};
         ee_mask_q <= '0;
      end else if (go && (op == NPS_OP_EE_BUF_LOAD)) begin
         ee_buf_q[cmd.ptr[NPS_EE_BYTE_W-1:0]] <= cmd.data[7:0];
         ee_mask_q[cmd.ptr[NPS_EE_BYTE_W-1:0]] <= 1'b1;
      end
   end

   // programmed lock bits read zero; a write can only clear further
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         lock_bits_q <= NPS_LOCK_RST;
      end else if (go && (op == NPS_OP_LOCK_WRITE)) begin
         lock_bits_q <= lock_bits_q & cmd.data[7:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checksum and flash read port

   nps_crc_step #(
      .DW(16)
   ) u_crc_step (
      .crc_in(crc_acc_q),
      .data_in(rd_word),
      .crc_out(crc_next)
   );

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         crc_acc_q <= NPS_CRC_INIT;
         crc_end_q <= NPS_WADDR_RST;
         crc_result_q <= NPS_CRC_INIT;
      end else if (state_q == NPS_ST_IDLE && crc_go) begin
         crc_acc_q <= NPS_CRC_INIT;
         crc_end_q <= crc_end_w;
      end else if (state_q == NPS_ST_CRC) begin
         crc_acc_q <= crc_next;
         if (crc_last && !bo_sync_q) begin
            crc_result_q <= crc_next;
         end
      end
   end

   logic rd_block;
   logic rd_take;
   logic [7:0] rd_pick;
   assign rd_block = crc_go || (state_q == NPS_ST_CRC) ||
                     ((state_q == NPS_ST_PROG) && (halt_all_q || rd_ptr[NPS_PAGE_FIELD_TOP_BIT:1] < NPS_BOOT_START_W));
   assign rd_take = rd_req && !rd_block && !rd_pend_q;
   assign rd_pick = rd_sel_q ? rd_word[15:8] : rd_word[7:0];

   // checksum walk owns the read port; one word address per clock
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_addr_q <= NPS_WADDR_RST;
         rd_sel_q <= 1'b0;
         rd_pend_q <= 1'b0;
      end else begin
         rd_pend_q <= rd_take;
         if (state_q == NPS_ST_IDLE && crc_go) begin
            rd_addr_q <= crc_start_w;
         end else if (state_q == NPS_ST_CRC) begin
            rd_addr_q <= rd_addr_q + NPS_WADDR_W'(1);
         end else if (rd_take) begin
            rd_addr_q <= rd_ptr[NPS_PAGE_FIELD_TOP_BIT:1];
            rd_sel_q <= rd_ptr[0];
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_byte_q <= 8'h00;
         rd_valid_q <= 1'b0;
         rd_refused_q <= 1'b0;
      end else begin
         rd_valid_q <= rd_pend_q;
         rd_refused_q <= rd_req && !rd_pend_q && rd_block;
         if (rd_pend_q) begin
            rd_byte_q <= rd_pick;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks

   logic in_crc;
   logic in_prog;
   assign in_crc = (state_q == NPS_ST_CRC);
   assign in_prog = (state_q == NPS_ST_PROG);

   sequence busy_cmd_s;
      busy_q && cmd_valid && (op != NPS_OP_NOP);
   endsequence

   sequence ignored_s;
      cmd_refused_q && !prog_start_q;
   endsequence

   busy_ignores_a: assert property (busy_cmd_s |=> ignored_s)
      else $error("command taken while busy");
   crc_halts_cpu_a: assert property (in_crc |-> cpu_halt_q && busy_q)
      else $error("cpu not halted during checksum");
   crc_one_word_a: assert property (in_crc && $past(in_crc) |-> rd_addr_q == $past(rd_addr_q) + 16'h0001)
      else $error("checksum address did not advance by one word");
   bod_on_write_a: assert property (prog_start_q && prog_req_q.target != NPS_TGT_EE |-> brownout_detector_en_q)
      else $error("brown-out detector off during flash write");
   brownout_abort_a: assert property (bo_sync_q && state_q != NPS_ST_IDLE |=> !busy_q && aborted_q)
      else $error("programming not aborted on brown-out");
   boot_halt_a: assert property (prog_start_q && halt_all_q && !bo_sync_q |-> cpu_halt_q [*2])
      else $error("cpu running during boot section programming");
   addr_latched_a: assert property (in_prog && $past(in_prog) |-> $stable(prog_req_q))
      else $error("target changed during page operation");
   byte_pick_a: assert property (rd_pend_q |=> rd_valid_q && rd_byte_q == $past(rd_pick))
      else $error("wrong byte returned for read");
   crc_hold_a: assert property (!in_crc |=> $stable(crc_result_q))
      else $error("checksum result changed outside checksum");
   app_priv_a: assert property (cmd_valid && needs_priv && !cmd.from_boot && !cmd.from_ext |=> !prog_start_q)
      else $error("application code started flash programming");

endmodule

// ===== bench/nps_flash_model.sv
/*
 Behavioural flash array seen by the sequencer's read and checksum port.
 Assumes the word is wanted in the same cycle as its address.
*/
`timescale 1ns/1ps

module nps_flash_model (
   input wire logic [15:0] addr,
   output logic [15:0] word
);
   // high byte changes every word, low byte every 256 words, so a byte swap or address slip shows
   assign word = {addr[7:0] ^ 8'h5A, addr[15:8] ^ 8'h3C};
endmodule

// ===== bench/nvm_page_program_sequencer_tb.sv
/*
 Self-checking bench of the page programming sequencer.
 Assumes a shortened page operation time and the flash model beside it.
*/
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin n_errors++; \
   $display("wrong value %s exp %0h got %0h", n, e, s); end end

module nvm_page_program_sequencer_tb;
   import nps_pkg::*;
   localparam int P = 5;
   logic clk = 0, rst_n = 0, cmd_valid = 0, rd_req = 0, fetch = 0, brown = 0;
   logic busy_q, cmd_refused_q, cmd_done_q, aborted_q, cpu_halt_q, bod_q, start_q, rd_valid_q, rd_refused_q;
   logic [23:0] rd_ptr = 0, fetch_ptr = 0, last = 0, crc_result_q;
   logic [15:0] rd_word, rd_addr_q, d;
   logic [31:0] seed = 32'h2AF9;
   logic [25:0] ev, got;
   logic [7:0] lock_bits_q, rd_byte_q;
   logic [NPS_FBUF_WORDS-1:0][15:0] fl_buf_q;
   logic [NPS_EE_BYTES-1:0][7:0] ee_buf_q;
   logic [NPS_EE_BYTES-1:0] ee_mask_q;
   nps_cmd_t cmd = '0;
   nps_prog_t prog_req_q;
   logic [25:0] q[$];
   int n_errors = 0, n_checks = 0, c, lo, hi;

   nps_sequencer #(.PAGE_OP_CYC(P)) uut (.clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd(cmd),
      .rd_req(rd_req), .rd_ptr(rd_ptr), .rd_word(rd_word), .cpu_fetch_valid(fetch), .cpu_fetch_ptr(fetch_ptr),
      .brownout_reset_in(brown), .busy_q(busy_q), .cmd_refused_q(cmd_refused_q), .cmd_done_q(cmd_done_q),
      .aborted_q(aborted_q), .cpu_halt_q(cpu_halt_q), .brownout_detector_en_q(bod_q), .prog_start_q(start_q),
      .prog_req_q(prog_req_q), .fl_buf_q(fl_buf_q), .ee_buf_q(ee_buf_q), .ee_mask_q(ee_mask_q),
      .lock_bits_q(lock_bits_q), .crc_result_q(crc_result_q), .rd_addr_q(rd_addr_q), .rd_byte_q(rd_byte_q),
      .rd_valid_q(rd_valid_q), .rd_refused_q(rd_refused_q));
   nps_flash_model mem (.addr(rd_addr_q), .word(rd_word));

   ////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] xs(logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction
   function automatic logic [15:0] pat(logic [15:0] a);
      return {a[7:0] ^ 8'h5A, a[15:8] ^ 8'h3C};
   endfunction
   function automatic logic [23:0] crc_f(int a, int b);
      logic [23:0] r;
      logic [15:0] w;
      r = NPS_CRC_INIT;
      for (int k = a; k <= b; k++) begin
         w = pat(k[15:0]);
         for (int i = 15; i >= 0; i--) r = (r << 1) ^ ((r[23] ^ w[i]) ? NPS_CRC_POLY : 24'h0);
      end
      return r;
   endfunction
   task automatic exp(logic [1:0] k, logic [23:0] v);
      q.push_back({k, v});
   endtask
   task automatic issue(nps_op_t op, logic [23:0] p, logic [23:0] e, logic boot, logic [15:0] dat);
      @(posedge clk);
      cmd_valid <= 1'b1;
      cmd <= '{op: op, ptr: p, range_end: e, data: dat, from_boot: boot, from_ext: 1'b0};
      @(posedge clk);
      cmd_valid <= 1'b0;
   endtask
   task automatic idle(output int n);
      n = 0;
      do begin
         @(posedge clk) #1;
         n++;
      end while (busy_q === 1'b1 && n < 70000);
      if (n >= 70000) n_errors++;
   endtask
   task automatic results;
      // notes never answered count as misses
      n_errors += q.size();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial forever #5 clk = ~clk;
   initial begin
      #1000000;
      n_errors++;
      results();
   end
   always @(negedge clk) if (rst_n && (cmd_done_q | cmd_refused_q | aborted_q | rd_valid_q) === 1'b1) begin
      got = {rd_valid_q ? 2'd3 : aborted_q ? 2'd2 : cmd_refused_q ? 2'd1 : 2'd0,
             rd_valid_q ? {16'h0, rd_byte_q} : crc_result_q};
      ev = q.size() > 0 ? q.pop_front() : '1;
      `CHK("result", ev, got)
   end

   initial begin
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      `CHK("lock", 8'hFF, lock_bits_q)
      `CHK("crc", 24'h0, crc_result_q)
      seed = xs(seed);
      d = seed[15:0];
      exp(0, last);
      issue(NPS_OP_FL_BUF_LOAD, 24'h000006, 0, 1, d);
      @(posedge clk) #1;
      `CHK("buffer", d, fl_buf_q[3])
      fetch <= 1'b1;
      fetch_ptr <= 24'h01E000;
      issue(NPS_OP_FL_ERASE, 24'h000140, 0, 1, 0);
      @(posedge clk) #1;
      `CHK("bod", 1'b1, bod_q)
      exp(1, last);
      issue(NPS_OP_FL_WRITE, 24'h000FC0, 0, 1, 0);
      `CHK("page", 11'd5, prog_req_q.page)
      `CHK("halt", 1'b0, cpu_halt_q)
      exp(0, last);
      idle(c);
      exp(0, last);
      issue(NPS_OP_FL_WRITE, 24'h000140, 0, 1, 0);
      idle(c);
      `CHK("cleared", 16'hFFFF, fl_buf_q[3])
      fetch <= 1'b0;
      for (int k = 0; k < 2; k++) begin
         exp(0, last);
         issue(k ? NPS_OP_SIG_WRITE : NPS_OP_FL_ERASE_WRITE, 24'h01E000, 0, 1, 0);
         @(posedge clk) #1;
         `CHK("halt", 1'b1, cpu_halt_q)
         idle(c);
      end
      exp(1, last);
      issue(NPS_OP_FL_ERASE, 24'h000140, 0, 0, 0);
      exp(0, last);
      issue(NPS_OP_EE_BUF_LOAD, 24'h000023, 0, 0, d);
      @(posedge clk) #1;
      `CHK("tag", 1'b1, ee_mask_q[3])
      `CHK("ee byte", d[7:0], ee_buf_q[3])
      exp(0, last);
      issue(NPS_OP_EE_ERASE_WRITE, 24'h000020, 0, 0, 0);
      idle(c);
      `CHK("tags", 32'h0, ee_mask_q)
      exp(2, last);
      issue(NPS_OP_FL_ERASE, 24'h000140, 0, 1, 0);
      repeat (2) @(posedge clk);
      brown <= 1'b1;
      idle(c);
      brown <= 1'b0;
      repeat (3) @(posedge clk);
      exp(0, last);
      issue(NPS_OP_FL_ERASE, 24'h000140, 0, 1, 0);
      rd_req <= 1'b1;
      rd_ptr <= 24'h000140;
      fetch <= 1'b1;
      fetch_ptr <= 24'h000140;
      @(posedge clk) #1;
      `CHK("refused", 1'b1, rd_refused_q)
      `CHK("stall", 1'b1, cpu_halt_q)
      rd_req <= 1'b0;
      fetch <= 1'b0;
      idle(c);
      // the long application checksum is kept: only it walks the full application section
      for (int k = 0; k < 3; k++) begin
         lo = k == 0 ? 0 : k == 1 ? 'hF000 : 4;
         hi = k == 0 ? 'hEFFF : k == 1 ? 'hFFFF : 5;
         last = crc_f(lo, hi);
         exp(0, last);
         issue(k == 0 ? NPS_OP_CRC_APP : k == 1 ? NPS_OP_CRC_BOOT : NPS_OP_CRC_RANGE,
               24'(lo * 2), 24'(hi * 2), 1'b1, 16'h0);
         @(posedge clk) #1;
         `CHK("halt", 1'b1, cpu_halt_q)
         idle(c);
         // one busy edge went to the halt check above
         `CHK("cycles", hi - lo + 1, c + 1)
      end
      exp(0, last);
      issue(NPS_OP_LOCK_WRITE, 0, 0, 1, 16'h00F0);
      @(posedge clk) #1;
      `CHK("lock", 8'hF0, lock_bits_q)
      exp(1, last);
      issue(NPS_OP_CRC_RANGE, 24'h00000A, 24'h000008, 1, 0);
      seed = xs(seed);
      for (int b = 0; b < 2; b++) begin
         d = pat({1'b0, seed[14:0]});
         exp(3, {16'h0, b ? d[15:8] : d[7:0]});
         @(posedge clk);
         rd_req <= 1'b1;
         rd_ptr <= {7'h0, 1'b0, seed[14:0], b[0]};
         @(posedge clk);
         rd_req <= 1'b0;
         repeat (3) @(posedge clk);
      end
      results();
   end
endmodule
